// ---- rbo_byte_order.v ----
// Contract
// - Pattern in high byte moves low via PAD
// - Plain mode: 8-bit pattern and PAD
// - Decoded mode: 9-bit values, top bit control
// - Sync rising edge starts new search
// - High-byte match inserts exactly one PAD
// - Low-byte match means ordered, no PAD
// - First match handled sets done
// - New sync edge clears done, searches again
// - User trigger edge starts same search
// - FIFO carries data and status across
// - Low latency: four deep, two-three cycles
// - High latency: eight deep, four-five cycles
// - Byte deserializer: FIFO runs half rate; here only reads slow down, writes land every cycle
// - Write clock source follows configuration; here writes always run on pclk
// - Error output on overflow or underflow
// - Sync status from word aligner hysteresis
// - Input words are two-byte deserialized
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "rbo_defines.vh"
module rbo_byte_order #(
    parameter DW = 16,                   // Two-byte word width
    parameter AW = 3                     // FIFO address width (eight entries)
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire          in_valid,
    input  wire [DW-1:0] in_data,
    input  wire [1:0]    in_ctrl,
    input  wire          sync_status,
    input  wire          order_trig,
    output reg           out_valid,
    output reg  [DW-1:0] out_data,
    output reg  [1:0]    out_ctrl,
    output reg           order_done,
    output reg           fifo_err
);
    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    reg  [5:0]    ctrl_reg;              // Control word
    reg  [8:0]    pattern_reg;           // Ordering pattern
    reg  [8:0]    pad_reg;               // PAD value
    reg           trig_prev_reg;         // Trigger source, last cycle
    reg           searching_reg;         // Looking for first match
    reg           shift_reg;             // One PAD inserted so far
    reg  [8:0]    carry_reg;             // Held high byte with its flag
    reg           ord_valid_reg;         // Ordered word valid
    reg  [DW-1:0] ord_data_reg;          // Ordered word
    reg  [1:0]    ord_ctrl_reg;          // Ordered control flags
    reg           half_reg;              // Half-rate divider
    reg  [DW+1:0] mem [0:(1<<AW)-1];     // FIFO storage
    reg  [AW-1:0] wptr_reg;              // Write pointer
    reg  [AW-1:0] rptr_reg;              // Read pointer
    reg  [AW:0]   count_reg;             // Fill level
    reg           primed_reg;            // Reading has started
    wire          act;                   // APB access completes
    wire          trig_src;              // Selected trigger
    wire          trig_rise;             // Rising edge of trigger
    wire          lo_hit;                // Low byte matches
    wire          hi_hit;                // High byte matches
    wire          tick;                  // FIFO read clock enable
    wire [1:0]    mode;                  // FIFO mode field
    wire [AW:0]   depth;                 // Depth for mode
    wire [AW:0]   prime;                 // Priming level for mode
    wire          wr_ok;                 // Write accepted
    wire          rd_go;                 // Read attempted
    wire          flush;                 // Control written
    wire          ovf_ev;                // Word offered to a full FIFO
    wire          unf_ev;                // Read tick on an empty FIFO
    reg  [31:0]   rd_mux;                // Read data select
    reg           hit_map;               // Address is mapped
    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign act   = psel & penable & pready;
    // Any control write restarts the FIFO from empty, so software
    // should not rewrite control while words are still in flight
    assign flush = act & pwrite & (paddr == `RBO_CTRL_OFF);
    // Read data and decode
    always @* begin
        rd_mux  = 32'h0000_0000;
        hit_map = 1'b1;
        case (paddr)
            `RBO_CTRL_OFF:    rd_mux = {26'h0, ctrl_reg};
            `RBO_PATTERN_OFF: rd_mux = {23'h0, pattern_reg};
            `RBO_PAD_OFF:     rd_mux = {23'h0, pad_reg};
            `RBO_STATUS_OFF:  rd_mux = {29'h0, primed_reg, fifo_err, order_done};
            default:          hit_map = 1'b0;
        endcase
    end
    // One wait state, so every answer comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= rd_mux;
            pslverr <= psel & penable & ~pready & ~hit_map;
        end
    end
    // Writable registers; status is read only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= `RBO_CTRL_RST;
            pattern_reg <= `RBO_PATTERN_RST;
            pad_reg     <= `RBO_PAD_RST;
        end else if (act & pwrite) begin
            case (paddr)
                `RBO_CTRL_OFF:    ctrl_reg    <= pwdata[5:0];
                `RBO_PATTERN_OFF: pattern_reg <= pwdata[8:0];
                `RBO_PAD_OFF:     pad_reg     <= pwdata[8:0];
                default:          ctrl_reg    <= ctrl_reg;
            endcase
        end
    end
    // ----------------------------------------
    // Trigger selection
    // ----------------------------------------
    // user trigger select
    assign trig_src  = ctrl_reg[`RBO_CTRL_USER] ? order_trig : sync_status;
    assign trig_rise = trig_src & ~trig_prev_reg;
    // Both sources are same-clock logic, no synchroniser
    // aligner status sampled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_src;
        end
    end
    // ----------------------------------------
    // Pattern compare
    // ----------------------------------------
    // nine-bit compare with control flag
    assign lo_hit = (in_data[7:0] == pattern_reg[7:0]) &
                    (~ctrl_reg[`RBO_CTRL_WIDE9] | (in_ctrl[0] == pattern_reg[8]));
    assign hi_hit = (in_data[15:8] == pattern_reg[7:0]) &
                    (~ctrl_reg[`RBO_CTRL_WIDE9] | (in_ctrl[1] == pattern_reg[8]));
    // ----------------------------------------
    // Byte ordering datapath
    // ----------------------------------------
    // A trigger clears the shift and drops the held byte; the
    // stream is expected to be realigned anyway, so a one-byte
    // gap at that moment is traded for a single held byte of storage.
    // two-byte input words
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            searching_reg <= 1'b0;
            shift_reg     <= 1'b0;
            carry_reg     <= 9'h000;
            order_done    <= 1'b0;
            ord_valid_reg <= 1'b0;
            ord_data_reg  <= {DW{1'b0}};
            ord_ctrl_reg  <= 2'h0;
        end else begin
            ord_valid_reg <= in_valid & ctrl_reg[`RBO_CTRL_ENA];
            if (trig_rise & ctrl_reg[`RBO_CTRL_ENA]) begin
                searching_reg <= 1'b1;
                shift_reg     <= 1'b0;
                order_done    <= 1'b0;
                ord_valid_reg <= 1'b0;
            end else if (in_valid & ctrl_reg[`RBO_CTRL_ENA]) begin
                carry_reg <= {in_ctrl[1], in_data[15:8]};
                if (searching_reg & lo_hit) begin
                    searching_reg <= 1'b0;
                    order_done    <= 1'b1;
                    ord_data_reg  <= in_data;
                    ord_ctrl_reg  <= in_ctrl;
                end else if (searching_reg & hi_hit) begin
                    searching_reg <= 1'b0;
                    shift_reg     <= 1'b1;
                    order_done    <= 1'b1;
                    ord_data_reg  <= {pad_reg[7:0], in_data[7:0]};
                    ord_ctrl_reg  <= {pad_reg[8], in_ctrl[0]};
                end else if (shift_reg) begin
                    // Shifted stream: held byte goes low
                    ord_data_reg  <= {in_data[7:0], carry_reg[7:0]};
                    ord_ctrl_reg  <= {in_ctrl[0], carry_reg[8]};
                end else begin
                    // Pass through unchanged
                    ord_data_reg  <= in_data;
                    ord_ctrl_reg  <= in_ctrl;
                end
            end
        end
    end
    // ----------------------------------------
    // Half-rate divider
    // ----------------------------------------
    // Writes still land every cycle, so at half rate the fabric drains
    // one word in two; a faster feed overflows by design
    // half-rate FIFO read enable
    assign tick = ~ctrl_reg[`RBO_CTRL_HALF] | half_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
        end
    end
    // ----------------------------------------
    // Phase compensation FIFO
    // ----------------------------------------
    assign mode  = ctrl_reg[`RBO_CTRL_MODE_HI:`RBO_CTRL_MODE_LO];
    assign depth = (mode == `RBO_MODE_HIGH) ? `RBO_DEPTH_HIGH : `RBO_DEPTH_LOW;
    assign prime = (mode == `RBO_MODE_HIGH) ? `RBO_PRIME_HIGH : `RBO_PRIME_LOW;
    assign rd_go = tick & primed_reg;
    // A read in the same cycle frees a slot, so a full FIFO still accepts
    assign wr_ok = ord_valid_reg & ((count_reg != depth) | (rd_go & (count_reg != 0)));
    // Error events, gated off in register mode where no FIFO runs
    assign ovf_ev = (mode != `RBO_MODE_REG) & ord_valid_reg & ~wr_ok;
    assign unf_ev = (mode != `RBO_MODE_REG) & rd_go & (count_reg == 0);
    always @(posedge pclk) begin
        if (wr_ok) begin
            mem[wptr_reg] <= {ord_ctrl_reg, ord_data_reg};
        end
    end
    // Pointers, fill level, priming and error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_reg   <= {AW{1'b0}};
            rptr_reg   <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            primed_reg <= 1'b0;
            fifo_err   <= 1'b0;
            out_valid  <= 1'b0;
            out_data   <= {DW{1'b0}};
            out_ctrl   <= 2'h0;
        end else if (flush) begin
            // Mode change empties the FIFO and clears the error, but an
            // overflow or underflow in that very cycle must not be lost
            // to software, so the event wins over the clear
            wptr_reg   <= {AW{1'b0}};
            rptr_reg   <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            primed_reg <= 1'b0;
            fifo_err   <= ovf_ev | unf_ev;
            out_valid  <= 1'b0;
        end else if (mode == `RBO_MODE_REG) begin
            out_valid <= ord_valid_reg;
            out_data  <= ord_data_reg;
            out_ctrl  <= ord_ctrl_reg;
        end else begin
            out_valid <= 1'b0;
            if (wr_ok) begin
                wptr_reg <= (wptr_reg == depth - 1) ? {AW{1'b0}} : wptr_reg + 1'b1;
            end
            if (count_reg >= prime) begin
                primed_reg <= 1'b1;
            end
            if (rd_go & (count_reg != 0)) begin
                out_valid <= 1'b1;
                {out_ctrl, out_data} <= mem[rptr_reg];
                rptr_reg <= (rptr_reg == depth - 1) ? {AW{1'b0}} : rptr_reg + 1'b1;
            end else if (rd_go) begin
                fifo_err   <= 1'b1;
                primed_reg <= 1'b0;
            end
            if (ovf_ev) begin
                fifo_err <= 1'b1;
            end
            // Fill level moves only when exactly one side acts
            case ({wr_ok, rd_go & (count_reg != 0)})
                2'b10:   count_reg <= count_reg + 1'b1;
                2'b01:   count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end
endmodule // rbo_byte_order

// ---- rbo_byte_order_monitor.sv ----
`timescale 1ns/100ps
`include "rbo_defines.vh"
// ----------------------------------------
// Port-level checker for the ordering block
// ----------------------------------------
module rbo_byte_order_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_valid,
    input wire logic        sync_status,
    input wire logic        order_trig,
    input wire logic        out_valid,
    input wire logic        order_done,
    input wire logic        fifo_err
);
    logic user_reg;  // Trigger source as last written
    logic regm_reg;  // Single-stage mode as last written
    wire  ctrl_wr = psel && penable && pready && pwrite && paddr == `RBO_CTRL_OFF;
    // Shadow the control bits, since the checker cannot see inside
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_reg <= 1'b0;
            regm_reg <= 1'b0;
        end else if (ctrl_wr) begin
            user_reg <= pwdata[`RBO_CTRL_USER];
            regm_reg <= pwdata[`RBO_CTRL_MODE_HI:`RBO_CTRL_MODE_LO] == `RBO_MODE_REG;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("ready not after one wait");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error read not zero");
    a_sync_clears_done: assert property (!user_reg && $rose(sync_status) |-> ##[1:3] !order_done)
        else $error("done kept after sync rise");
    a_user_clears_done: assert property (user_reg && $rose(order_trig) |-> ##[1:3] !order_done)
        else $error("done kept after user trigger");
    a_done_needs_word: assert property ($rose(order_done) |-> $past(in_valid)) else $error("done without word");
    a_err_sticky: assert property (fifo_err && !ctrl_wr |=> fifo_err) else $error("error flag dropped");
    a_reg_two_cycles: assert property (regm_reg && out_valid |-> $past(in_valid, 2))
        else $error("register stage latency wrong");
endmodule // rbo_byte_order_monitor

// ---- rbo_defines.vh ----
`ifndef RBO_DEFINES_VH
`define RBO_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RBO_CTRL_OFF     8'h00
`define RBO_PATTERN_OFF  8'h04
`define RBO_PAD_OFF      8'h08
`define RBO_STATUS_OFF   8'h0c
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define RBO_CTRL_ENA     0
`define RBO_CTRL_USER    1
`define RBO_CTRL_MODE_LO 2
`define RBO_CTRL_MODE_HI 3
`define RBO_CTRL_WIDE9   4
`define RBO_CTRL_HALF    5
// ----------------------------------------
// Status field positions
// ----------------------------------------
`define RBO_STAT_DONE    0
`define RBO_STAT_ERR     1
`define RBO_STAT_PRIMED  2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RBO_CTRL_RST     6'h01
`define RBO_PATTERN_RST  9'h000
`define RBO_PAD_RST      9'h000
// ----------------------------------------
// FIFO modes, depths, priming levels
// ----------------------------------------
`define RBO_MODE_LOW     2'h0
`define RBO_MODE_HIGH    2'h1
`define RBO_MODE_REG     2'h2
`define RBO_DEPTH_LOW    4'h4
`define RBO_DEPTH_HIGH   4'h8
`define RBO_PRIME_LOW    4'h2
`define RBO_PRIME_HIGH   4'h4
`endif

// ---- rbo_fabric_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Fabric side: word sink and trigger source
// ----------------------------------------
module rbo_fabric_model (
    input  wire logic        pclk,
    input  wire logic        trig_req,
    input  wire logic        out_valid,
    input  wire logic [15:0] out_data,
    input  wire logic [1:0]  out_ctrl,
    output wire logic        order_trig
);
    logic [17:0] words[$];          // Every word the fabric took
    logic [1:0]  hold_reg = 2'h0;   // Cycles left on the trigger level
    always @(posedge pclk) begin
        if (trig_req)
            hold_reg <= 2'h3;
        else if (hold_reg != 2'h0)
            hold_reg <= hold_reg - 2'h1;
    end
    assign order_trig = hold_reg != 2'h0;
    // read side shares the write clock, no stall possible
    always @(posedge pclk)
        if (out_valid === 1'b1) words.push_back({out_ctrl, out_data});
endmodule // rbo_fabric_model

// ---- rbo_testbench.sv ----
`timescale 1ns/100ps
`include "rbo_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic        pclk = 1'b0;        // Single clock, 20 ns
    logic        presetn = 1'b0;     // Active-low reset
    logic        psel = 1'b0;        // Bus select
    logic        penable = 1'b0;     // Bus access phase
    logic        pwrite = 1'b0;      // Bus direction
    logic [7:0]  paddr = 8'h00;      // Bus byte address
    logic [31:0] pwdata = 32'h0;     // Bus write data
    logic [31:0] prdata, rd;         // Read data, last taken
    logic        pready, pslverr, err;
    logic        in_valid = 1'b0;    // Stream word strobe
    logic [15:0] in_data = 16'h0;    // Two-byte input word
    logic [1:0]  in_ctrl = 2'h0;     // Per-byte flags
    logic        sync_status = 1'b0; // Aligner lock level
    logic        trig_req = 1'b0;    // Asks the fabric for a trigger
    logic        order_trig, out_valid, order_done, fifo_err;
    logic [15:0] out_data;
    logic [1:0]  out_ctrl;
    logic [17:0] exp_q[$];           // Words the fabric should see
    int          fails = 0, n_tests = 0, cyc = 0, i;
    rbo_byte_order dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .in_valid, .in_data, .in_ctrl, .sync_status, .order_trig, .out_valid, .out_data,
        .out_ctrl, .order_done, .fifo_err);
    rbo_fabric_model fab (.pclk, .trig_req, .out_valid, .out_data, .out_ctrl, .order_trig);
    always #10 pclk = ~pclk;
    // Cut a hang short; the whole run needs well under this
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Bus and stream drivers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request held until ready is seen at an edge
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic send(input logic [17:0] w);
        in_valid <= 1'b1;
        {in_ctrl, in_data} <= w;
        @(posedge pclk);
    endtask
    // ----------------------------------------
    // One trigger and ordering pass
    // ----------------------------------------
    task automatic run(input int n);
        logic [1:0]  mode;
        logic [8:0]  pat, pad;
        logic [17:0] w[4];
        logic        hi, usr, w9;
        int          k;
        mode = 2'(n % 3);
        hi = n >= 3;
        usr = n % 2;
        w9 = (n / 2) % 2;
        pat = 9'($urandom);
        pad = 9'($urandom) & {w9, 8'hff};
        apb(1'b1, `RBO_PATTERN_OFF, {23'h0, pat}, rd, err);
        apb(1'b1, `RBO_PAD_OFF, {23'h0, pad}, rd, err);
        apb(1'b1, `RBO_CTRL_OFF, {27'h0, w9, mode, usr, 1'b1}, rd, err);
        // Low first in sync mode, so the next rise is a fresh edge
        sync_status <= usr;
        repeat (3) @(posedge pclk);
        if (usr) trig_req <= 1'b1;
        else sync_status <= 1'b1;
        @(posedge pclk);
        trig_req <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(order_done, 1'b0)
        for (k = 0; k < 4; k++) begin
            w[k] = 18'($urandom);
            if (w[k][7:0] == pat[7:0]) w[k][0] = ~w[k][0];
            if (w[k][15:8] == pat[7:0]) w[k][8] = ~w[k][8];
        end
        // pattern straddled high, or low (then also high, low wins)
        {w[0][17], w[0][15:8]} = pat;
        if (!hi) {w[0][16], w[0][7:0]} = pat;
        if (!hi && !w9) w[0][16] = ~pat[8];
        if (hi && w9) {w[0][16], w[0][7:0]} = {~pat[8], pat[7:0]};
        exp_q = {};
        fab.words = {};
        for (k = 0; k < 4; k++) begin
            if (!hi) exp_q.push_back(w[k]);
            else if (k == 0) exp_q.push_back({pad[8], w[0][16], pad[7:0], w[0][7:0]});
            else exp_q.push_back({w[k][16], w[k-1][17], w[k][7:0], w[k-1][15:8]});
            send(w[k]);
        end
        in_valid <= 1'b0;
        for (k = 0; k < 40 && fab.words.size() < 4; k++) @(posedge pclk);
        `CHK(order_done, 1'b1)
        `CHK(fab.words.size(), 4)
        for (k = 0; k < 4; k++) `CHK(fab.words[k], exp_q[k])
        apb(1'b0, `RBO_STATUS_OFF, 32'h0, rd, err);
        `CHK({err, rd[`RBO_STAT_DONE]}, 2'b01)
        $display("ordering pass %0d mode %0d high %0d user %0d done", n, mode, hi, usr);
    endtask
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(23058));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `RBO_CTRL_OFF, 32'h0, rd, err);
        `CHK(rd, 32'h1)
        for (i = 1; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd, err);
            `CHK(rd, 32'h0)
        end
        // Unmapped place answers with an error and zero data
        apb(1'b0, 8'h10, 32'h0, rd, err);
        `CHK({err, rd}, 33'h1_0000_0000)
        $display("register reset test done");
        for (i = 0; i < 6; i++) run(i);
        // Half-rate reads cannot keep up with a word every cycle
        apb(1'b1, `RBO_CTRL_OFF, 32'h21, rd, err);
        for (i = 0; i < 12; i++) send(18'($urandom));
        in_valid <= 1'b0;
        // Let the drain and its closing underflow finish, so the clear
        // below meets no new error event in the same cycle
        repeat (20) @(posedge pclk);
        `CHK(fifo_err, 1'b1)
        apb(1'b0, `RBO_STATUS_OFF, 32'h0, rd, err);
        `CHK(rd[`RBO_STAT_ERR], 1'b1)
        apb(1'b1, `RBO_CTRL_OFF, 32'h0, rd, err);
        `CHK(fifo_err, 1'b0)
        // Words offered while disabled must vanish
        fab.words = {};
        for (i = 0; i < 3; i++) send(18'($urandom));
        in_valid <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK(fab.words.size(), 0)
        $display("overflow and disable test done");
        tally_and_finish();
    end
endmodule // testbench
bind rbo_byte_order rbo_byte_order_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_valid, .sync_status, .order_trig, .out_valid, .order_done, .fifo_err);
